// File: logic/dpo_map.svh
// register offsets, field positions, reset values and bus constants of the
// oscillator pull-word register bank; included by the design and verification files
`ifndef DPO_MAP_SVH
`define DPO_MAP_SVH

// register offsets (8-bit register pointer)
`define DPO_OFS_FREQ_LOWER     8'h00
`define DPO_OFS_OE_FREQ_UPPER  8'h01

// fields of the upper register
`define DPO_UPPER_MSB          9
`define DPO_UPPER_W            10
`define DPO_OE_BIT             10
`define DPO_UNUSED_W           5

// word widths
`define DPO_LOWER_W            16
`define DPO_PULL_W             26
`define DPO_REG_W              16

// reset values
`define DPO_RST_LOWER          16'h0000
`define DPO_RST_UPPER          10'h000
`define DPO_RST_OE             1'b0

// serial target address, arbitrary value
`define DPO_TARGET_ADDR        7'h60
// bits per serial byte
`define DPO_BYTE_BITS          4'h8

`endif

// File: logic/dpo_pkg.sv
// types shared by the pull-word register bank
// stands alone; needs nothing from dpo_map.svh
package dpo_pkg;

  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RX      = 3'b001,
    ST_RX_ACK  = 3'b010,
    ST_TX      = 3'b011,
    ST_TX_ACK  = 3'b100,
    ST_TX_NEXT = 3'b101
  } dpo_state_t;

  // which byte of a write transfer comes next
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_PTR  = 2'b01,
    PH_DATA = 2'b10
  } dpo_phase_t;

endpackage

// File: logic/dpo_bus_edges.sv
// edge and bus-condition detector for the two-wire target port
// assumes scl and sda levels already synchronous to clk_i
`timescale 1ns/10ps
`default_nettype none

module dpo_bus_edges (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // wire levels
  input  wire logic scl_i,
  input  wire logic sda_i,
  // detected events, one cycle each
  output logic      scl_rise_o,
  output logic      scl_fall_o,
  output logic      start_o,
  output logic      stop_o
);

  logic scl_q_ff;
  logic sda_q_ff;

  // previous levels; idle bus reads high
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
    end
  end

  // sda moving while scl stays high marks start or stop
  assign scl_rise_o = scl_i & ~scl_q_ff;
  assign scl_fall_o = ~scl_i & scl_q_ff;
  assign start_o    = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  assign stop_o     = scl_i & scl_q_ff & ~sda_q_ff & sda_i;

endmodule

`default_nettype wire

// File: logic/dpo_pull_word_regs.sv
// Function
// [RULE1] upper register bits 15:11 read zero; writes to them are dropped
// [RULE2] bit 10 is software output enable; zero disables, reset zero
// [RULE3] under pin control, writes to bit 10 do not touch the driver
// [RULE4] bits 9:0 are the top ten bits of the 26-bit pull word
// [RULE5] lower sixteen pull-word bits come from the lower register at offset zero
// [RULE6] after reset all 26 pull-word bits are zero, nominal frequency
// [RULE7] the pull word is a signed two's complement value
// [RULE8] change starts only on upper-word load; controller writes lower first
// [RULE9] controller commits pull-word updates no faster than 38 kHz
// [RULE10] registers reached only as two-wire bus target, up to 1 Mbit/s
// [RULE11] reads return stored enable and upper word, unused bits zero
//
// top of the oscillator pull-word register bank with its two-wire target
// assumes SCL/SDA synchronous to REF_CLK_I; the pad combines SDA_O/SDA_OE_O
`timescale 1ns/10ps
`default_nettype none
`include "dpo_map.svh"

module dpo_pull_word_regs #(
  parameter logic [6:0] TARGET_ADDR = `DPO_TARGET_ADDR
) (
  // clock and reset
  input  wire logic                      REF_CLK_I,
  input  wire logic                      NRST_I,
  // two-wire bus
  input  wire logic                      SCL_I,
  input  wire logic                      SDA_I,
  output var  logic                      SDA_O,
  output var  logic                      SDA_OE_O,
  // output enable control
  input  wire logic                      OE_SW_CTRL_I,
  input  wire logic                      OE_PIN_I,
  output var  logic                      OUT_EN_O,
  // committed pull word
  output var  logic signed [`DPO_PULL_W-1:0] FREQ_PULL_WORD_O,
  output var  logic                      FREQ_UPDATE_O
);

  logic                     scl_rise;
  logic                     scl_fall;
  logic                     bus_start;
  logic                     bus_stop;
  dpo_pkg::dpo_state_t      state_ff;
  dpo_pkg::dpo_phase_t      phase_ff;
  logic [3:0]               bit_cnt_ff;
  logic [7:0]               rx_ff;
  logic [7:0]               tx_ff;
  logic                     rw_ff;
  logic [7:0]               ptr_ff;
  logic                     hilo_ff;
  logic [7:0]               hold_hi_ff;
  logic                     sda_oe_ff;
  logic                     wr_en_ff;
  logic [7:0]               wr_ofs_ff;
  logic [`DPO_REG_W-1:0]    wr_data_ff;
  logic [`DPO_LOWER_W-1:0]  freq_word_lower_ff;
  logic [`DPO_UPPER_W-1:0]  freq_word_upper_ff;
  logic                     oe_sw_ff;
  logic [`DPO_REG_W-1:0]    rd_word;
  logic [7:0]               nxt_tx_byte;
  logic [7:0]               rx_byte;

  dpo_bus_edges u_edges (
    .clk_i      (REF_CLK_I),
    .nrst_i     (NRST_I),
    .scl_i      (SCL_I),
    .sda_i      (SDA_I),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .start_o    (bus_start),
    .stop_o     (bus_stop)
  );

  // read view of the register addressed by the pointer
  always_comb begin
    rd_word = '0;
    if (ptr_ff == `DPO_OFS_FREQ_LOWER) begin
      rd_word = freq_word_lower_ff;
    end else if (ptr_ff == `DPO_OFS_OE_FREQ_UPPER) begin
      rd_word = {{`DPO_UNUSED_W{1'b0}}, oe_sw_ff, freq_word_upper_ff}; // [RULE1] [RULE11]
    end
  end

  // high byte first, matching the wire's msb-first order
  assign nxt_tx_byte = hilo_ff ? rd_word[7:0] : rd_word[15:8];
  // byte as completed on the eighth rising edge
  assign rx_byte     = rx_ff;

  // byte-level target engine; only the target role exists, no controller
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin // [RULE10]
    if (!NRST_I) begin
      state_ff   <= dpo_pkg::ST_IDLE;
      phase_ff   <= dpo_pkg::PH_ADDR;
      bit_cnt_ff <= 4'h0;
      rx_ff      <= 8'h00;
      tx_ff      <= 8'h00;
      rw_ff      <= 1'b0;
      ptr_ff     <= 8'h00;
      hilo_ff    <= 1'b0;
      hold_hi_ff <= 8'h00;
      sda_oe_ff  <= 1'b0;
      wr_en_ff   <= 1'b0;
      wr_ofs_ff  <= 8'h00;
      wr_data_ff <= 16'h0000;
    end else begin
      wr_en_ff <= 1'b0;
      if (bus_start) begin
        // a repeated start also lands here and restarts the address phase
        state_ff   <= dpo_pkg::ST_RX;
        phase_ff   <= dpo_pkg::PH_ADDR;
        bit_cnt_ff <= 4'h0;
        rw_ff      <= 1'b0;
        hilo_ff    <= 1'b0;
        sda_oe_ff  <= 1'b0;
      end else if (bus_stop) begin
        state_ff  <= dpo_pkg::ST_IDLE;
        sda_oe_ff <= 1'b0;
      end else begin
        unique case (state_ff)
          dpo_pkg::ST_IDLE: begin
            sda_oe_ff <= 1'b0;
          end
          dpo_pkg::ST_RX: begin
            if (scl_rise && bit_cnt_ff != `DPO_BYTE_BITS) begin
              rx_ff      <= {rx_ff[6:0], SDA_I};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_fall && bit_cnt_ff == `DPO_BYTE_BITS) begin
              bit_cnt_ff <= 4'h0;
              unique case (phase_ff)
                dpo_pkg::PH_ADDR: begin
                  if (rx_byte[7:1] == TARGET_ADDR) begin
                    rw_ff     <= rx_byte[0];
                    phase_ff  <= dpo_pkg::PH_PTR;
                    sda_oe_ff <= 1'b1;
                    state_ff  <= dpo_pkg::ST_RX_ACK;
                  end else begin
                    // another target's address: stay off the wire
                    state_ff <= dpo_pkg::ST_IDLE;
                  end
                end
                dpo_pkg::PH_PTR: begin
                  ptr_ff    <= rx_byte;
                  hilo_ff   <= 1'b0;
                  phase_ff  <= dpo_pkg::PH_DATA;
                  sda_oe_ff <= 1'b1;
                  state_ff  <= dpo_pkg::ST_RX_ACK;
                end
                default: begin
                  // data byte; second byte of a pair commits the word
                  if (!hilo_ff) begin
                    hold_hi_ff <= rx_byte;
                  end else begin
                    wr_en_ff   <= 1'b1;
                    wr_ofs_ff  <= ptr_ff;
                    wr_data_ff <= {hold_hi_ff, rx_byte};
                    ptr_ff     <= ptr_ff + 8'h01;
                  end
                  hilo_ff   <= ~hilo_ff;
                  sda_oe_ff <= 1'b1;
                  state_ff  <= dpo_pkg::ST_RX_ACK;
                end
              endcase
            end
          end
          dpo_pkg::ST_RX_ACK: begin
            if (scl_fall) begin
              if (rw_ff) begin
                // read address acked: first data bit goes out now
                sda_oe_ff  <= ~nxt_tx_byte[7];
                tx_ff      <= {nxt_tx_byte[6:0], 1'b0};
                bit_cnt_ff <= 4'h1;
                hilo_ff    <= ~hilo_ff;
                if (hilo_ff) begin
                  ptr_ff <= ptr_ff + 8'h01;
                end
                state_ff <= dpo_pkg::ST_TX;
              end else begin
                sda_oe_ff <= 1'b0;
                state_ff  <= dpo_pkg::ST_RX;
              end
            end
          end
          dpo_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_ff == `DPO_BYTE_BITS) begin
                sda_oe_ff  <= 1'b0;
                bit_cnt_ff <= 4'h0;
                state_ff   <= dpo_pkg::ST_TX_ACK;
              end else begin
                // open drain: drive only for a zero bit
                sda_oe_ff  <= ~tx_ff[7];
                tx_ff      <= {tx_ff[6:0], 1'b0};
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
              end
            end
          end
          dpo_pkg::ST_TX_ACK: begin
            if (scl_rise) begin
              // controller nack ends the read; wait for stop or start
              state_ff <= SDA_I ? dpo_pkg::ST_IDLE : dpo_pkg::ST_TX_NEXT;
            end
          end
          dpo_pkg::ST_TX_NEXT: begin
            if (scl_fall) begin
              sda_oe_ff  <= ~nxt_tx_byte[7];
              tx_ff      <= {nxt_tx_byte[6:0], 1'b0};
              bit_cnt_ff <= 4'h1;
              hilo_ff    <= ~hilo_ff;
              if (hilo_ff) begin
                ptr_ff <= ptr_ff + 8'h01;
              end
              state_ff <= dpo_pkg::ST_TX;
            end
          end
          default: begin
            state_ff  <= dpo_pkg::ST_IDLE;
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // lower word only waits in a holding register until the upper load
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      freq_word_lower_ff <= `DPO_RST_LOWER; // [RULE6]
    end else if (wr_en_ff && wr_ofs_ff == `DPO_OFS_FREQ_LOWER) begin
      freq_word_lower_ff <= wr_data_ff; // [RULE5]
    end
  end

  // upper word and software enable; bits 15:11 are never stored
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      freq_word_upper_ff <= `DPO_RST_UPPER; // [RULE6]
      oe_sw_ff           <= `DPO_RST_OE; // [RULE2]
    end else if (wr_en_ff && wr_ofs_ff == `DPO_OFS_OE_FREQ_UPPER) begin
      freq_word_upper_ff <= wr_data_ff[`DPO_UPPER_MSB:0]; // [RULE4] [RULE1]
      if (OE_SW_CTRL_I) begin
        oe_sw_ff <= wr_data_ff[`DPO_OE_BIT]; // [RULE3]
      end
    end
  end

  // commit on upper load only; no rate limiting, the controller paces it
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      FREQ_PULL_WORD_O <= '0; // [RULE6]
      FREQ_UPDATE_O    <= 1'b0;
    end else begin
      FREQ_UPDATE_O <= 1'b0;
      if (wr_en_ff && wr_ofs_ff == `DPO_OFS_OE_FREQ_UPPER) begin
        // signed concat: upper bit 9 is the sign of the whole word
        FREQ_PULL_WORD_O <= $signed({wr_data_ff[`DPO_UPPER_MSB:0],
                                     freq_word_lower_ff}); // [RULE8] [RULE7] [RULE9]
        FREQ_UPDATE_O    <= 1'b1; // [RULE8]
      end
    end
  end

  // driver enable: software bit or pin, chosen by the mode input
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      OUT_EN_O <= 1'b0;
    end else begin
      OUT_EN_O <= OE_SW_CTRL_I ? oe_sw_ff : OE_PIN_I; // [RULE2] [RULE3]
    end
  end

  // pad outputs; data line only ever pulled low
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      SDA_O <= 1'b0;
    end else begin
      SDA_O <= 1'b0;
    end
  end

  assign SDA_OE_O = sda_oe_ff;

endmodule

`default_nettype wire

// File: verif/dpo_props.sv
// concurrent checks on the ports of the pull-word register bank
// assumes one clock domain and the port names of the top module
`timescale 1ns/10ps
`default_nettype none
`include "dpo_map.svh"

module dpo_props (
  // clock and reset
  input wire logic                          REF_CLK_I,
  input wire logic                          NRST_I,
  // two-wire bus
  input wire logic                          SCL_I,
  input wire logic                          SDA_O,
  input wire logic                          SDA_OE_O,
  // enable and pull word
  input wire logic                          OE_SW_CTRL_I,
  input wire logic                          OE_PIN_I,
  input wire logic                          OUT_EN_O,
  input wire logic signed [`DPO_PULL_W-1:0] FREQ_PULL_WORD_O,
  input wire logic                          FREQ_UPDATE_O
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  // open-drain: only ever pulls low
  property p_sda_low; SDA_O == 1'b0; endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda drive not low");
  property p_upd_pulse; FREQ_UPDATE_O |=> !FREQ_UPDATE_O; endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("update pulse too long");
  property p_word_hold; $changed(FREQ_PULL_WORD_O) |-> FREQ_UPDATE_O; endproperty
  a_word_hold: assert property (p_word_hold) else $error("word moved without commit");
  property p_pin_ctrl; !OE_SW_CTRL_I |=> OUT_EN_O == $past(OE_PIN_I); endproperty
  a_pin_ctrl: assert property (p_pin_ctrl) else $error("driver not following pin");
  property p_sw_oe;
    $changed(OUT_EN_O) && $past(OE_SW_CTRL_I) && $past(OE_SW_CTRL_I, 2) |-> $past(FREQ_UPDATE_O);
  endproperty
  a_sw_oe: assert property (p_sw_oe) else $error("enable moved without a write");
  // target may only move sda while the bus clock is low
  property p_sda_scl; $changed(SDA_OE_O) |-> !SCL_I; endproperty
  a_sda_scl: assert property (p_sda_scl) else $error("sda moved with scl high");
  property p_commit_ack; FREQ_UPDATE_O |-> SDA_OE_O && !SCL_I; endproperty
  a_commit_ack: assert property (p_commit_ack) else $error("commit outside ack");
  property p_rst_zero;
    $rose(NRST_I) |-> FREQ_PULL_WORD_O == '0 && !OUT_EN_O && !SDA_OE_O && !FREQ_UPDATE_O;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("outputs not clear at reset");
endmodule

bind dpo_pull_word_regs dpo_props u_props (
  .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .SCL_I(SCL_I), .SDA_O(SDA_O),
  .SDA_OE_O(SDA_OE_O), .OE_SW_CTRL_I(OE_SW_CTRL_I), .OE_PIN_I(OE_PIN_I),
  .OUT_EN_O(OUT_EN_O), .FREQ_PULL_WORD_O(FREQ_PULL_WORD_O), .FREQ_UPDATE_O(FREQ_UPDATE_O)
);
`default_nettype wire

// File: verif/dpo_i2c_host.sv
// behavioural two-wire bus controller that writes and reads the registers
// assumes a pull-up on sda, resolved by the surrounding testbench
`timescale 1ns/10ps
`default_nettype none
`include "dpo_map.svh"

module dpo_i2c_host #(
  parameter logic [6:0] TARGET_ADDR = `DPO_TARGET_ADDR
) (
  // clock
  input  wire logic clk_i,
  // resolved data line
  input  wire logic sda_i,
  // bus drive, sda_oe_o high pulls low
  output var  logic scl_o,
  output var  logic sda_oe_o
);
  // bus released at time zero
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  // quarter bit, 128 cycles a bit keeps under 1 Mbit/s
  task automatic half();
    repeat (32) @(posedge clk_i);
    #1;
  endtask
  // start or repeated start, leaves scl low
  task automatic start();
    sda_oe_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    sda_oe_o = 1'b1;
    half();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    half();
    sda_oe_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    sda_oe_o = 1'b0;
    half();
  endtask
  // one bit, msb first ordering is the caller's
  task automatic bit_io(input logic b, output logic r);
    half();
    sda_oe_o = ~b;
    half();
    scl_o = 1'b1;
    half();
    r = sda_i;
    half();
    scl_o = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                       output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ack_in, r);
    ack = ~r;
  endtask
  // whole write lasts far beyond the 38 kHz commit spacing
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] v,
                    output logic ok);
    logic [7:0] q;
    logic       k;
    start();
    xbyte({a, 1'b0}, 1'b1, q, ok);
    xbyte(p, 1'b1, q, k);
    ok = ok & k;
    xbyte(v[15:8], 1'b1, q, k);
    ok = ok & k;
    xbyte(v[7:0], 1'b1, q, k);
    ok = ok & k;
    stop();
  endtask
  // pointer write, repeated start, two bytes with nack on the last
  task automatic rd(input logic [7:0] p, output logic [15:0] v);
    logic [7:0] q;
    logic       k;
    start();
    xbyte({TARGET_ADDR, 1'b0}, 1'b1, q, k);
    xbyte(p, 1'b1, q, k);
    start();
    xbyte({TARGET_ADDR, 1'b1}, 1'b1, q, k);
    xbyte(8'hff, 1'b0, v[15:8], k);
    xbyte(8'hff, 1'b1, v[7:0], k);
    stop();
  endtask
endmodule
`default_nettype wire

// File: verif/dpo_pull_word_regs_test.sv
// self-checking bench for the pull-word register bank
// assumes the bus controller model and the bound checker are compiled
`timescale 1ns/10ps
`default_nettype none
`include "dpo_map.svh"

module dpo_pull_word_regs_test;
  logic                          ref_clk, nrst, sw, pin, sda_bus, sda_o, sda_oe, out_en, upd;
  logic                          scl, host_oe, ok;
  logic [15:0]                   v;
  logic signed [`DPO_PULL_W-1:0] word;
  int                            n_errors, compares, n_upd;

  // wired-and of both pull-downs with a pull-up
  assign sda_bus = !(host_oe || (sda_oe && !sda_o));
  dpo_i2c_host host (.clk_i(ref_clk), .sda_i(sda_bus), .scl_o(scl), .sda_oe_o(host_oe));
  dpo_pull_word_regs dut (
    .REF_CLK_I(ref_clk), .NRST_I(nrst), .SCL_I(scl), .SDA_I(sda_bus), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .OE_SW_CTRL_I(sw), .OE_PIN_I(pin), .OUT_EN_O(out_en),
    .FREQ_PULL_WORD_O(word), .FREQ_UPDATE_O(upd)
  );
  always #4 ref_clk = ~ref_clk;
  // count commits, a missed or doubled one shows in the totals
  always @(posedge ref_clk) if (upd === 1'b1) n_upd++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // watchdog well above the roughly 53k cycles of traffic
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_errors++;
    wrap_up();
  end
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    sw = 1'b1;
    pin = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    settle();
    chk(word, 32'h0);
    chk(out_en, 32'h0);
    host.rd(`DPO_OFS_OE_FREQ_UPPER, v);
    chk(v, 32'h0);
    host.wr(`DPO_TARGET_ADDR, `DPO_OFS_FREQ_LOWER, 16'h1234, ok);
    chk(ok, 32'h1);
    chk(word, 32'h0);
    host.wr(`DPO_TARGET_ADDR, `DPO_OFS_OE_FREQ_UPPER, 16'hfc05, ok);
    chk(word, 32'h0051234);
    chk(out_en, 32'h1);
    chk(n_upd, 32'h1);
    host.rd(`DPO_OFS_OE_FREQ_UPPER, v);
    chk(v, 32'h0405);
    host.rd(`DPO_OFS_FREQ_LOWER, v);
    chk(v, 32'h1234);
    host.wr(`DPO_TARGET_ADDR, `DPO_OFS_FREQ_LOWER, 16'h0000, ok);
    host.wr(`DPO_TARGET_ADDR, `DPO_OFS_OE_FREQ_UPPER, 16'h07ff, ok);
    chk(word, 32'hffff0000);
    // pin control: bit 10 written low must not reach the driver
    sw = 1'b0;
    pin = 1'b1;
    host.wr(`DPO_TARGET_ADDR, `DPO_OFS_OE_FREQ_UPPER, 16'h0000, ok);
    chk(out_en, 32'h1);
    chk(word, 32'h0);
    pin = 1'b0;
    settle();
    chk(out_en, 32'h0);
    sw = 1'b1;
    settle();
    chk(out_en, 32'h1);
    host.rd(`DPO_OFS_OE_FREQ_UPPER, v);
    chk(v, 32'h0400);
    // wrong target address is not acknowledged nor committed
    host.wr(`DPO_TARGET_ADDR ^ 7'h01, `DPO_OFS_OE_FREQ_UPPER, 16'h0155, ok);
    chk(ok, 32'h0);
    chk(n_upd, 32'h3);
    nrst = 1'b0;
    settle();
    chk(out_en, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
